/* File: design/pac_pkg.sv */
// package: register map, field positions and counts for the pulse accumulator
package pac_pkg;
   // apb byte offsets
   localparam logic [7:0] ADDR_COUNT = 8'h00;
   localparam logic [7:0] ADDR_CTRL  = 8'h04;
   localparam logic [7:0] ADDR_FLAG  = 8'h08;
   localparam logic [7:0] ADDR_MASK  = 8'h0C;
   localparam logic [7:0] ADDR_PIN   = 8'h10;
   // control fields
   localparam int CTRL_EDGE = 4;
   localparam int CTRL_MODE = 5;
   localparam int CTRL_EN   = 6;
   // flag and mask fields
   localparam int FLG_OVF  = 4;
   localparam int FLG_EDGE = 5;
   // reset values
   localparam logic [7:0] CTRL_RST  = 8'h00;
   localparam logic [7:0] COUNT_RST = 8'h00;
   // gated mode prescale
   localparam int DIV_COUNT = 64;
   localparam int DIV_W     = 6;
endpackage

/* File: design/pac_top.sv */
// pulse accumulator: event count and gated time mode behind an apb slave
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
module pac_top
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        pulse_input_pin,
   output logic             irq,
   output logic             irq_ovf,
   output logic             irq_edge
);

   logic [7:0]             pulse_count_value_q;
   logic [7:0]             ctrl_q;
   logic                   count_overflow_flag_q;
   logic                   input_edge_flag_q;
   logic                   overflow_irq_enable_q;
   logic                   input_edge_irq_enable_q;
   logic [pac_pkg::DIV_W-1:0] div_q;
   logic                   pin_s1_q;
   logic                   pin_s2_q;
   logic                   pin_prev_q;
   logic [31:0]            prdata_q;

   logic edge_polarity_select;
   logic gated_mode_select;
   logic accumulator_enable_bit;
   logic wr;
   logic rd;
   logic sel_edge;
   logic gate_open;
   logic tick;
   logic inc;
   logic ovf_set;
   logic edge_set;
   logic clr_ovf;
   logic clr_edge;
   logic cnt_wr;

   assign edge_polarity_select   = ctrl_q[pac_pkg::CTRL_EDGE];
   assign gated_mode_select      = ctrl_q[pac_pkg::CTRL_MODE];
   assign accumulator_enable_bit = ctrl_q[pac_pkg::CTRL_EN];

   assign wr = psel && penable && pwrite && ce;
   // reads fetch in the setup cycle so data stands in the access cycle
   assign rd = psel && !penable && !pwrite && ce;
   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign prdata  = prdata_q;

   // pin synchroniser, only the second stage feeds logic
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pin_s1_q   <= 1'b0;
         pin_s2_q   <= 1'b0;
         pin_prev_q <= 1'b0;
      end
      else if (ce)
      begin
         pin_s1_q   <= pulse_input_pin;
         pin_s2_q   <= pin_s1_q;
         pin_prev_q <= pin_s2_q;
      end
   end

   // polarity decode
   // 0: falling edge, low inhibits; 1: rising edge, high inhibits
   assign sel_edge = edge_polarity_select ? (pin_s2_q && !pin_prev_q)
                                          : (!pin_s2_q && pin_prev_q);
   assign gate_open = (pin_s2_q != edge_polarity_select);

   // free-running prescaler, never reset by the pin so gating is loose
   always_ff @(posedge clk)
   begin
      if (rst)
         div_q <= '0;
      else if (ce)
         div_q <= div_q + 1'b1;
   end
   assign tick = (div_q == pac_pkg::DIV_W'(pac_pkg::DIV_COUNT - 1));

   assign inc = accumulator_enable_bit &&
                (gated_mode_select ? (tick && gate_open) : sel_edge);

   // a preset landing on the same edge swallows the increment
   assign cnt_wr   = wr && paddr == pac_pkg::ADDR_COUNT;
   // ff to 00 is the overflow
   assign ovf_set  = inc && (pulse_count_value_q == 8'hFF) && !cnt_wr;
   // selected edge, i.e. gate trailing edge in gated mode
   assign edge_set = accumulator_enable_bit && sel_edge;

   // software preset wins over a count in the same cycle
   always_ff @(posedge clk)
   begin
      if (rst)
         pulse_count_value_q <= pac_pkg::COUNT_RST;
      else if (ce)
      begin
         if (wr && paddr == pac_pkg::ADDR_COUNT)
            pulse_count_value_q <= pwdata[7:0];
         else if (inc)
            pulse_count_value_q <= pulse_count_value_q + 8'h01;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ctrl_q                  <= pac_pkg::CTRL_RST;
         overflow_irq_enable_q   <= 1'b0;
         input_edge_irq_enable_q <= 1'b0;
      end
      else if (wr && paddr == pac_pkg::ADDR_CTRL)
         ctrl_q <= pwdata[7:0];
      else if (wr && paddr == pac_pkg::ADDR_MASK)
      begin
         overflow_irq_enable_q   <= pwdata[pac_pkg::FLG_OVF];
         input_edge_irq_enable_q <= pwdata[pac_pkg::FLG_EDGE];
      end
   end

   assign clr_ovf  = wr && paddr == pac_pkg::ADDR_FLAG
                     && pwdata[pac_pkg::FLG_OVF];
   assign clr_edge = wr && paddr == pac_pkg::ADDR_FLAG
                     && pwdata[pac_pkg::FLG_EDGE];

   // pending overflow still flagged at gate end
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         count_overflow_flag_q <= 1'b0;
         input_edge_flag_q     <= 1'b0;
      end
      else if (ce)
      begin
         if (ovf_set)
            count_overflow_flag_q <= 1'b1;
         else if (clr_ovf)
            count_overflow_flag_q <= 1'b0;
         if (edge_set)
            input_edge_flag_q <= 1'b1;
         else if (clr_edge)
            input_edge_flag_q <= 1'b0;
      end
   end

   assign irq_ovf  = count_overflow_flag_q && overflow_irq_enable_q;
   // edge request hidden while overflow requests
   assign irq_edge = input_edge_flag_q && input_edge_irq_enable_q
                     && !irq_ovf;
   assign irq      = irq_ovf || irq_edge;

   // read mux, unmapped reads zero
   always_ff @(posedge clk)
   begin
      if (rst)
         prdata_q <= 32'h0000_0000;
      else if (rd)
      begin
         unique case (paddr)
            pac_pkg::ADDR_COUNT: prdata_q <= {24'h00_0000,
                                              pulse_count_value_q};
            pac_pkg::ADDR_CTRL:  prdata_q <= {24'h00_0000, ctrl_q};
            pac_pkg::ADDR_FLAG:  prdata_q <= {26'h000_0000,
                                              input_edge_flag_q,
                                              count_overflow_flag_q,
                                              4'h0};
            pac_pkg::ADDR_MASK:  prdata_q <= {26'h000_0000,
                                              input_edge_irq_enable_q,
                                              overflow_irq_enable_q,
                                              4'h0};
            pac_pkg::ADDR_PIN:   prdata_q <= {31'h0000_0000, pin_s2_q};
            default:             prdata_q <= 32'h0000_0000;
         endcase
      end
   end

   // assertions
   property p_event_inc;
      @(posedge clk) disable iff (rst)
      ce && accumulator_enable_bit && !gated_mode_select && sel_edge
      && !(wr && paddr == pac_pkg::ADDR_COUNT)
      |=> pulse_count_value_q == $past(pulse_count_value_q) + 8'h01;
   endproperty
   a_event_inc: assert property (p_event_inc)
      else $error("event mode missed a count");

   property p_preset;
      @(posedge clk) disable iff (rst)
      wr && paddr == pac_pkg::ADDR_COUNT
      |=> pulse_count_value_q == $past(pwdata[7:0]);
   endproperty
   a_preset: assert property (p_preset)
      else $error("preset not loaded");

   property p_wrap;
      @(posedge clk) disable iff (rst)
      ce && inc && pulse_count_value_q == 8'hFF
      && !(wr && paddr == pac_pkg::ADDR_COUNT)
      |=> pulse_count_value_q == 8'h00 && count_overflow_flag_q;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("wrap did not flag overflow");

   property p_gated_hold;
      @(posedge clk) disable iff (rst)
      ce && gated_mode_select && !gate_open
      && !(wr && paddr == pac_pkg::ADDR_COUNT)
      |=> $stable(pulse_count_value_q);
   endproperty
   a_gated_hold: assert property (p_gated_hold)
      else $error("count moved at inhibit level");

   property p_tick_spacing;
      @(posedge clk) disable iff (rst || !ce)
      ce && tick |=> !tick [*8];
   endproperty
   a_tick_spacing: assert property (p_tick_spacing)
      else $error("prescale tick too frequent");

   property p_disabled;
      @(posedge clk) disable iff (rst)
      !accumulator_enable_bit && !count_overflow_flag_q
      && !input_edge_flag_q |=> !count_overflow_flag_q
      && !input_edge_flag_q;
   endproperty
   a_disabled: assert property (p_disabled)
      else $error("flag set while disabled");

   property p_clr_ovf;
      @(posedge clk) disable iff (rst)
      ce && clr_ovf && !ovf_set |=> !count_overflow_flag_q;
   endproperty
   a_clr_ovf: assert property (p_clr_ovf)
      else $error("overflow flag not cleared");

   property p_set_wins;
      @(posedge clk) disable iff (rst)
      ce && edge_set && clr_edge |=> input_edge_flag_q;
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("edge event lost to clear");

   property p_priority;
      @(posedge clk) disable iff (rst)
      irq_ovf |-> !irq_edge && irq;
   endproperty
   a_priority: assert property (p_priority)
      else $error("edge irq shown over overflow");

   property p_edge_flag;
      @(posedge clk) disable iff (rst)
      ce && edge_set |=> input_edge_flag_q;
   endproperty
   a_edge_flag: assert property (p_edge_flag)
      else $error("gate end did not set edge flag");

   property p_clr_edge;
      @(posedge clk) disable iff (rst)
      ce && clr_edge && !edge_set |=> !input_edge_flag_q;
   endproperty
   a_clr_edge: assert property (p_clr_edge)
      else $error("edge flag not cleared");

   property p_keep_ovf;
      @(posedge clk) disable iff (rst)
      count_overflow_flag_q && !clr_ovf |=> count_overflow_flag_q;
   endproperty
   a_keep_ovf: assert property (p_keep_ovf)
      else $error("overflow flag dropped without a clear");

   property p_no_clear;
      @(posedge clk) disable iff (rst)
      !cnt_wr |=> pulse_count_value_q == $past(pulse_count_value_q)
      || pulse_count_value_q == $past(pulse_count_value_q) + 8'h01;
   endproperty
   a_no_clear: assert property (p_no_clear)
      else $error("count jumped without a preset");

   property p_gated_inc;
      @(posedge clk) disable iff (rst)
      ce && accumulator_enable_bit && gated_mode_select && tick && gate_open
      && !cnt_wr
      |=> pulse_count_value_q == $past(pulse_count_value_q) + 8'h01;
   endproperty
   a_gated_inc: assert property (p_gated_inc)
      else $error("gated tick not counted");

   property p_rise_count;
      @(posedge clk) disable iff (rst)
      ce && accumulator_enable_bit && !gated_mode_select
      && edge_polarity_select && pin_s2_q && !pin_prev_q && !cnt_wr
      |=> pulse_count_value_q == $past(pulse_count_value_q) + 8'h01;
   endproperty
   a_rise_count: assert property (p_rise_count)
      else $error("rising edge not counted");

   property p_disabled_hold;
      @(posedge clk) disable iff (rst)
      !accumulator_enable_bit && !cnt_wr |=> $stable(pulse_count_value_q);
   endproperty
   a_disabled_hold: assert property (p_disabled_hold)
      else $error("count moved while disabled");

   c_overflow: cover property (@(posedge clk) disable iff (rst) ovf_set);
   c_gate_end: cover property (@(posedge clk) disable iff (rst)
      gated_mode_select && edge_set);
   c_both: cover property (@(posedge clk) disable iff (rst)
      count_overflow_flag_q && input_edge_flag_q);
   c_set_clear: cover property (@(posedge clk) disable iff (rst)
      edge_set && clr_edge);

endmodule // pac_top

/* File: tb/pac_pulse_src.sv */
// partner model: pulse source on the accumulator input pin
`timescale 1ns/1ps
module pac_pulse_src
(
   input  wire logic        clk,
   input  wire logic        start,
   input  wire logic        idle,
   input  wire logic [8:0]  n,
   input  wire logic [15:0] width,
   output logic             pin,
   output logic             busy
);
   // each level held width cycles, at least 3 so no edge is lost
   initial
   begin
      pin  = 1'b1;
      busy = 1'b0;
      forever
      begin
         @(posedge clk);
         if (start)
         begin
            busy <= 1'b1;
            repeat (n)
            begin
               pin <= !idle;
               repeat (width) @(posedge clk);
               pin <= idle;
               repeat (width) @(posedge clk);
            end
            busy <= 1'b0;
         end
         else
            pin <= idle;
      end
   end
endmodule // pac_pulse_src

/* File: tb/test_pulse_accumulator_counting.sv */
// testbench: apb driven checks of the pulse accumulator
`timescale 1ns/1ps
module test_pulse_accumulator_counting;
   typedef struct packed {
      logic       edge_sel;
      logic [7:0] preset;
      logic [8:0] n;
      logic [7:0] cnt;
      logic [7:0] flg;
   } pac_row_t;
   logic        clk, rst, psel, penable, pwrite, pready, pslverr;
   logic        pin, irq, irq_ovf, irq_edge, p_start, p_idle, p_busy;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic [8:0]  p_n;
   logic [15:0] p_w;
   int          n_fail, checked;
   pac_row_t    rows[5] = '{
      '{1'b0, 8'h00, 9'h005, 8'h05, 8'h20},
      '{1'b1, 8'h00, 9'h003, 8'h03, 8'h20},
      '{1'b0, 8'h9C, 9'h064, 8'h00, 8'h30},
      '{1'b1, 8'hFD, 9'h003, 8'h00, 8'h30},
      '{1'b0, 8'h00, 9'h100, 8'h00, 8'h30}};
   logic [7:0]  ra[5] = '{pac_pkg::ADDR_COUNT, pac_pkg::ADDR_CTRL,
      pac_pkg::ADDR_FLAG, pac_pkg::ADDR_MASK, 8'h20};

   pac_top pac_top_inst (.clk(clk), .rst(rst), .ce(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pulse_input_pin(pin), .irq(irq), .irq_ovf(irq_ovf),
      .irq_edge(irq_edge));
   pac_pulse_src pac_pulse_src_inst (.clk(clk), .start(p_start),
      .idle(p_idle), .n(p_n), .width(p_w), .pin(pin), .busy(p_busy));

   always #4 clk = ~clk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // apb transfer: hold everything until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [7:0] d, output logic [31:0] r);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h00_0000, d};
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      apb(1'b1, a, d, r);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      logic [31:0] r;
      apb(1'b0, a, 8'h00, r);
      chk(r, {24'h00_0000, e});
   endtask

   task automatic pulse(input logic [8:0] cnt, input logic [15:0] w);
      @(posedge clk);
      p_n     <= cnt;
      p_w     <= w;
      p_start <= 1'b1;
      @(posedge clk);
      p_start <= 1'b0;
      @(posedge clk);
      while (p_busy) @(posedge clk);
      // let the two-flop synchroniser and the flag update settle
      repeat (6) @(posedge clk);
   endtask

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial
   begin
      repeat (30000) @(posedge clk);
      n_fail++;
      final_report;
   end

   initial
   begin
      clk = 1'b0;
      rst = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {p_start, p_idle, p_n} = '0;
      p_w = 16'h0004;
      n_fail = 0;
      checked = 0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      foreach (rows[i])
      begin
         p_idle <= rows[i].edge_sel;
         wr(pac_pkg::ADDR_CTRL, 8'h00);
         wr(pac_pkg::ADDR_FLAG, 8'h30);
         wr(pac_pkg::ADDR_COUNT, rows[i].preset);
         wr(pac_pkg::ADDR_CTRL, {3'h2, rows[i].edge_sel, 4'h0});
         pulse(rows[i].n, 16'h0004);
         rd(pac_pkg::ADDR_COUNT, rows[i].cnt);
         rd(pac_pkg::ADDR_FLAG, rows[i].flg);
      end
      $display("event count rows done");
      // second reset in mid-run, flags were set and count had wrapped to 00
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      foreach (ra[j])
         rd(ra[j], 8'h00);
      chk({30'h0000_0000, pready, pslverr}, 32'h0000_0002);
      $display("reset and unmapped done");
      p_idle <= 1'b1;
      // pin must sit at the inhibit level before gated mode is armed
      repeat (4) @(posedge clk);
      wr(pac_pkg::ADDR_CTRL, 8'h70);
      repeat (200) @(posedge clk);
      rd(pac_pkg::ADDR_COUNT, 8'h00);
      rd(pac_pkg::ADDR_PIN, 8'h01);
      pulse(9'h001, 16'h0280);
      rd(pac_pkg::ADDR_COUNT, 8'h0A);
      rd(pac_pkg::ADDR_FLAG, 8'h20);
      pulse(9'h001, 16'h0140);
      rd(pac_pkg::ADDR_COUNT, 8'h0F);
      wr(pac_pkg::ADDR_MASK, 8'h30);
      wr(pac_pkg::ADDR_FLAG, 8'h30);
      wr(pac_pkg::ADDR_COUNT, 8'hFB);
      pulse(9'h001, 16'h0140);
      rd(pac_pkg::ADDR_COUNT, 8'h00);
      rd(pac_pkg::ADDR_FLAG, 8'h30);
      chk({29'h0000_0000, irq, irq_ovf, irq_edge}, 32'h0000_0006);
      wr(pac_pkg::ADDR_FLAG, 8'h00);
      rd(pac_pkg::ADDR_FLAG, 8'h30);
      wr(pac_pkg::ADDR_FLAG, 8'h10);
      rd(pac_pkg::ADDR_FLAG, 8'h20);
      chk({29'h0000_0000, irq, irq_ovf, irq_edge}, 32'h0000_0005);
      wr(pac_pkg::ADDR_MASK, 8'h10);
      @(posedge clk);
      chk({31'h0000_0000, irq}, 32'h0000_0000);
      wr(pac_pkg::ADDR_FLAG, 8'h20);
      rd(pac_pkg::ADDR_FLAG, 8'h00);
      $display("gated mode and flags done");
      wr(pac_pkg::ADDR_CTRL, 8'h10);
      wr(pac_pkg::ADDR_COUNT, 8'h07);
      pulse(9'h003, 16'h0004);
      rd(pac_pkg::ADDR_COUNT, 8'h07);
      rd(pac_pkg::ADDR_FLAG, 8'h00);
      $display("disabled hold done");
      // flag clear write lands on the edge that sets the flag
      p_idle <= 1'b0;
      repeat (4) @(posedge clk);
      wr(pac_pkg::ADDR_CTRL, 8'h40);
      @(posedge clk);
      p_n     <= 9'h001;
      p_start <= 1'b1;
      @(posedge clk);
      p_start <= 1'b0;
      repeat (4) @(posedge clk);
      wr(pac_pkg::ADDR_FLAG, 8'h20);
      rd(pac_pkg::ADDR_FLAG, 8'h20);
      $display("set versus clear done");
      final_report;
   end
endmodule // test_pulse_accumulator_counting
